// file: sac_pkg.sv
// Purpose: shared constants and types of the converter control unit
// Assumes: 8-bit special-function register port, one clock
// Notes:   offsets are byte addresses on that port
`default_nettype none

package sac_pkg;

  // ********************************************************
  // register port
  // ********************************************************
  localparam int unsigned SAC_ADDR_W = 8;
  localparam int unsigned SAC_DATA_W = 8;

  localparam logic [7:0] SAC_OFS_PAIR_CFG = 8'hba;
  localparam logic [7:0] SAC_OFS_CHAN_SEL = 8'hbb;
  localparam logic [7:0] SAC_OFS_CLK_GAIN = 8'hbc;
  localparam logic [7:0] SAC_OFS_RES_LO   = 8'hbe;
  localparam logic [7:0] SAC_OFS_RES_HI   = 8'hbf;
  localparam logic [7:0] SAC_OFS_CTRL     = 8'he8;

  localparam logic [7:0] SAC_RST_PAIR_CFG = 8'h00;
  localparam logic [7:0] SAC_RST_CHAN_SEL = 8'h00;
  localparam logic [7:0] SAC_RST_CLK_GAIN = 8'hf8;
  localparam logic [7:0] SAC_RST_RES      = 8'h00;
  localparam logic [7:0] SAC_RST_CTRL     = 8'h00;
  localparam logic [7:0] SAC_LOW_NIBBLE   = 8'h0f;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int unsigned SAC_CTL_ENABLE = 7;
  localparam int unsigned SAC_CTL_TRACK  = 6;
  localparam int unsigned SAC_CTL_DONE   = 5;
  localparam int unsigned SAC_CTL_BUSY   = 4;
  localparam int unsigned SAC_CTL_MODE_H = 3;
  localparam int unsigned SAC_CTL_MODE_L = 2;
  localparam int unsigned SAC_CTL_WINDOW = 1;
  localparam int unsigned SAC_CTL_LJUST  = 0;
  localparam int unsigned SAC_CFG_DIV_H  = 7;
  localparam int unsigned SAC_CFG_DIV_L  = 3;
  localparam int unsigned SAC_CFG_GAIN_H = 2;
  localparam int unsigned SAC_CFG_GAIN_L = 0;
  localparam int unsigned SAC_CHAN_TEMP  = 3;

  localparam int unsigned SAC_DIV_W      = 5;
  localparam int unsigned SAC_RES_W      = 10;
  localparam int unsigned SAC_PAD_W      = 6;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int unsigned SAC_TRACK_SAR_CLKS = 3;
  localparam int unsigned SAC_CONV_SAR_CLKS  = 11;
  localparam int unsigned SAC_CNT_W          = 4;

  // ********************************************************
  // enumerations
  // ********************************************************
  typedef enum logic [1:0] {
    SAC_START_WRITE = 2'b00,
    SAC_START_TMR3  = 2'b01,
    SAC_START_EXT   = 2'b10,
    SAC_START_TMR2  = 2'b11
  } sac_start_t;

  typedef enum logic [1:0] {
    SAC_ST_IDLE  = 2'b00,
    SAC_ST_TRACK = 2'b01,
    SAC_ST_CONV  = 2'b10
  } sac_state_t;

  typedef enum logic [2:0] {
    SAC_GAIN_X1   = 3'h0,
    SAC_GAIN_X2   = 3'h1,
    SAC_GAIN_X4   = 3'h2,
    SAC_GAIN_X8   = 3'h3,
    SAC_GAIN_X16  = 3'h4,
    SAC_GAIN_HALF = 3'h5
  } sac_gain_t;

endpackage

`default_nettype wire

// file: sac_sar_clock.sv
// Purpose: sar clock tick generator from the system clock
// Assumes: divisor held stable while running
// Notes:   one tick every divisor+1 cycles, phase restarts when run drops
`default_nettype none

module sac_sar_clock
  import sac_pkg::*;
#(
  parameter int unsigned DIV_W = sac_pkg::SAC_DIV_W
)(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // control
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  // tick
  output logic                  sar_tick
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } sac_div_t;

  sac_div_t state_reg;
  sac_div_t state_next;

  // restart on every run so the first tick is a full period away
  assign sar_tick = run && (state_reg.cnt == divisor);

  always_comb
  begin
    state_next = state_reg;
    if (!run || sar_tick)
    begin
      state_next.cnt = '0;
    end
    else
    begin
      state_next.cnt = state_reg.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule

`default_nettype wire

// file: sac_control.sv
// Purpose: digital control of a 10-bit successive-approximation converter
// Assumes: analog core supplies its result when the last sar clock ends
// Notes:   window limits arrive as ports from their own registers
`default_nettype none

module sac_control
  import sac_pkg::*;
#(
  parameter int unsigned CONV_SAR_CLKS = sac_pkg::SAC_CONV_SAR_CLKS
)(
  // clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            sys_rst,
  // special-function register port
  input  wire logic [sac_pkg::SAC_ADDR_W-1:0]  sfr_addr,
  input  wire logic                            sfr_wr,
  input  wire logic [sac_pkg::SAC_DATA_W-1:0]  sfr_wdata,
  output logic      [sac_pkg::SAC_DATA_W-1:0]  sfr_rdata,
  // conversion triggers
  input  wire logic                            timer3_overflow,
  input  wire logic                            timer2_overflow,
  input  wire logic                            external_start_input,
  // window limits
  input  wire logic [15:0]                     window_gt_limit,
  input  wire logic [15:0]                     window_lt_limit,
  // analog core
  input  wire logic [sac_pkg::SAC_RES_W-1:0]   analog_result,
  output logic                                 converter_active,
  output logic                                 track_active,
  output logic                                 convert_active,
  output logic                                 sar_clock_tick,
  output logic      [2:0]                      mux_input_pos,
  output logic                                 mux_differential,
  output logic                                 mux_temp_sensor,
  output sac_pkg::sac_gain_t                   amplifier_gain,
  // flags
  output logic                                 conversion_done_flag,
  output logic                                 window_match_flag
);

  // ********************************************************
  // helper functions
  // ********************************************************
  function automatic sac_gain_t sac_gain_decode(input logic [2:0] sel);
    sac_gain_t g;
    g = SAC_GAIN_X1;
    unique case (sel)
      3'h0: g = SAC_GAIN_X1;
      3'h1: g = SAC_GAIN_X2;
      3'h2: g = SAC_GAIN_X4;
      3'h3: g = SAC_GAIN_X8;
      3'h4, 3'h5: g = SAC_GAIN_X16;
      3'h6, 3'h7: g = SAC_GAIN_HALF;
    endcase
    return g;
  endfunction

  function automatic logic [15:0] sac_format(input logic [SAC_RES_W-1:0] raw,
                                             input logic diff, input logic ljust);
    logic [15:0] w;
    w = ljust ? {raw, {SAC_PAD_W{1'b0}}}
              : {{SAC_PAD_W{diff & raw[SAC_RES_W-1]}}, raw};
    return w;
  endfunction

  // signed compare for differential data, unsigned for single-ended
  function automatic logic sac_less(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    logic signed [16:0] ea;
    logic signed [16:0] eb;
    ea = {sgn & a[15], a};
    eb = {sgn & b[15], b};
    return ea < eb;
  endfunction

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic [3:0]               pair_cfg;
    logic [3:0]               channel_code;
    logic [7:0]               clk_gain;
    logic [7:0]               res_lo;
    logic [7:0]               res_hi;
    logic                     enable;
    logic                     track_mode;
    logic                     done;
    logic [1:0]               start_mode;
    logic                     window;
    logic                     left_justify;
    sac_state_t               st;
    logic [SAC_CNT_W-1:0]     cnt;
    logic                     ext_s1;
    logic                     ext_s2;
    logic                     ext_prev;
    logic [7:0]               rdata;
  } sac_ctl_t;

  sac_ctl_t state_reg;
  sac_ctl_t state_next;

  logic                     sar_tick;
  logic                     sel_diff;
  logic                     wr_ctrl;
  logic                     sw_start;
  logic                     ext_rise;
  logic                     trigger;
  logic [15:0]              new_word;
  logic                     in_window_mode;
  logic                     win_hit;
  logic [7:0]               ctrl_view;

  // ********************************************************
  // sar clock
  // ********************************************************
  sac_sar_clock #(
    .DIV_W     (SAC_DIV_W)
  ) u_sar_clock (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .run       (state_reg.st != SAC_ST_IDLE),
    .divisor   (state_reg.clk_gain[SAC_CFG_DIV_H:SAC_CFG_DIV_L]),
    .sar_tick  (sar_tick)
  );

  // ********************************************************
  // analog steering
  // ********************************************************
  // odd code of a differential pair is steered to the pair's even input
  assign sel_diff = !state_reg.channel_code[SAC_CHAN_TEMP]
                    && state_reg.pair_cfg[state_reg.channel_code[2:1]];

  assign mux_temp_sensor  = state_reg.channel_code[SAC_CHAN_TEMP];
  assign mux_differential = sel_diff;
  assign mux_input_pos    = sel_diff ? {state_reg.channel_code[2:1], 1'b0}
                                     : state_reg.channel_code[2:0];

  assign amplifier_gain   = sac_gain_decode(state_reg.clk_gain[SAC_CFG_GAIN_H:SAC_CFG_GAIN_L]);
  assign converter_active = state_reg.enable;
  assign convert_active   = state_reg.st == SAC_ST_CONV;
  assign sar_clock_tick   = sar_tick;

  // low-power external mode tracks while the pin is low and idle
  assign track_active = !state_reg.enable ? 1'b0
                      : !state_reg.track_mode ? (state_reg.st == SAC_ST_IDLE)
                      : (state_reg.start_mode == SAC_START_EXT)
                        ? ((state_reg.st == SAC_ST_IDLE) && !state_reg.ext_s2)
                      : (state_reg.st == SAC_ST_TRACK);

  // ********************************************************
  // triggers
  // ********************************************************
  assign wr_ctrl  = sfr_wr && (sfr_addr == SAC_OFS_CTRL);
  // a start needs write mode both in the register and in the mode bits of this write
  assign sw_start = wr_ctrl && sfr_wdata[SAC_CTL_BUSY]
                    && (sfr_wdata[SAC_CTL_MODE_H:SAC_CTL_MODE_L] == SAC_START_WRITE);
  assign ext_rise = state_reg.ext_s2 && !state_reg.ext_prev;

  always_comb
  begin
    trigger = 1'b0;
    unique case (sac_start_t'(state_reg.start_mode))
      SAC_START_WRITE: trigger = sw_start;
      SAC_START_TMR3:  trigger = timer3_overflow;
      SAC_START_EXT:   trigger = ext_rise;
      SAC_START_TMR2:  trigger = timer2_overflow;
    endcase
  end

  // ********************************************************
  // result and window
  // ********************************************************
  assign new_word       = sac_format(analog_result, sel_diff, state_reg.left_justify);
  // limits in order mean the window flags inside, crossed over outside
  assign in_window_mode = sac_less(window_gt_limit, window_lt_limit, sel_diff);
  assign win_hit        = in_window_mode
                          ? (sac_less(window_gt_limit, new_word, sel_diff)
                             && sac_less(new_word, window_lt_limit, sel_diff))
                          : (sac_less(new_word, window_lt_limit, sel_diff)
                             || sac_less(window_gt_limit, new_word, sel_diff));

  assign ctrl_view = {state_reg.enable, state_reg.track_mode, state_reg.done,
                      state_reg.st != SAC_ST_IDLE, state_reg.start_mode,
                      state_reg.window, state_reg.left_justify};

  // ********************************************************
  // next state
  // ********************************************************
  always_comb
  begin
    state_next          = state_reg;
    state_next.ext_s1   = external_start_input;
    state_next.ext_s2   = state_reg.ext_s1;
    state_next.ext_prev = state_reg.ext_s2;

    if (sfr_wr)
    begin
      unique case (sfr_addr)
        SAC_OFS_PAIR_CFG: state_next.pair_cfg = sfr_wdata[3:0];
        SAC_OFS_CHAN_SEL: state_next.channel_code = sfr_wdata[3:0];
        SAC_OFS_CLK_GAIN: state_next.clk_gain = sfr_wdata;
        SAC_OFS_RES_LO:   state_next.res_lo = sfr_wdata;
        SAC_OFS_RES_HI:   state_next.res_hi = sfr_wdata;
        SAC_OFS_CTRL:
        begin
          state_next.enable       = sfr_wdata[SAC_CTL_ENABLE];
          state_next.track_mode   = sfr_wdata[SAC_CTL_TRACK];
          state_next.done         = sfr_wdata[SAC_CTL_DONE];
          state_next.start_mode   = sfr_wdata[SAC_CTL_MODE_H:SAC_CTL_MODE_L];
          state_next.window       = sfr_wdata[SAC_CTL_WINDOW];
          state_next.left_justify = sfr_wdata[SAC_CTL_LJUST];
        end
        default: ;
      endcase
    end

    unique case (state_reg.st)
      SAC_ST_IDLE:
      begin
        state_next.cnt = '0;
        if (state_reg.enable && trigger)
        begin
          state_next.st = (state_reg.track_mode && (state_reg.start_mode != SAC_START_EXT))
                          ? SAC_ST_TRACK
                          : SAC_ST_CONV;
        end
      end
      SAC_ST_TRACK:
      begin
        if (sar_tick)
        begin
          if (state_reg.cnt == SAC_CNT_W'(SAC_TRACK_SAR_CLKS - 1))
          begin
            state_next.st  = SAC_ST_CONV;
            state_next.cnt = '0;
          end
          else
          begin
            state_next.cnt = state_reg.cnt + {{(SAC_CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end
      SAC_ST_CONV:
      begin
        if (sar_tick)
        begin
          if (state_reg.cnt == SAC_CNT_W'(CONV_SAR_CLKS - 1))
          begin
            state_next.st     = SAC_ST_IDLE;
            state_next.res_hi = new_word[15:8];
            state_next.res_lo = new_word[7:0];
            // hardware set wins over a software clear in the same cycle
            state_next.done   = 1'b1;
            if (win_hit)
            begin
              state_next.window = 1'b1;
            end
          end
          else
          begin
            state_next.cnt = state_reg.cnt + {{(SAC_CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end
      default:
      begin
        state_next.st = SAC_ST_IDLE;
      end
    endcase

    // shutdown aborts a running conversion without a completion unless written in the cycle of its last sar tick
    if (!state_next.enable)
    begin
      state_next.st = SAC_ST_IDLE;
    end

    unique case (sfr_addr)
      SAC_OFS_PAIR_CFG: state_next.rdata = {4'h0, state_reg.pair_cfg};
      SAC_OFS_CHAN_SEL: state_next.rdata = {4'h0, state_reg.channel_code};
      SAC_OFS_CLK_GAIN: state_next.rdata = state_reg.clk_gain;
      SAC_OFS_RES_LO:   state_next.rdata = state_reg.res_lo;
      SAC_OFS_RES_HI:   state_next.rdata = state_reg.res_hi;
      SAC_OFS_CTRL:     state_next.rdata = ctrl_view;
      default:          state_next.rdata = 8'h00;
    endcase
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg              <= '0;
      state_reg.pair_cfg     <= SAC_RST_PAIR_CFG[3:0];
      state_reg.channel_code <= SAC_RST_CHAN_SEL[3:0];
      state_reg.clk_gain     <= SAC_RST_CLK_GAIN;
      state_reg.res_lo       <= SAC_RST_RES;
      state_reg.res_hi       <= SAC_RST_RES;
      state_reg.st           <= SAC_ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign sfr_rdata            = state_reg.rdata;
  assign conversion_done_flag = state_reg.done;
  assign window_match_flag    = state_reg.window;

endmodule

`default_nettype wire

// file: sac_control_sva.sv
// Purpose: port-level checks of the converter control unit
// Assumes: one clock, reset asynchronous and active high
// Notes:   bound to every instance of the top module
`default_nettype none

module sac_control_sva
  import sac_pkg::*;
#(
  parameter int unsigned CONV_SAR_CLKS = 11
)(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       sys_rst,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // converter and mux
  input wire logic       converter_active,
  input wire logic       track_active,
  input wire logic       convert_active,
  input wire logic       sar_clock_tick,
  input wire logic [2:0] mux_input_pos,
  input wire logic       mux_differential,
  input wire logic       mux_temp_sensor,
  // flags
  input wire logic       conversion_done_flag,
  input wire logic       window_match_flag
);
  // ********************************************************
  // helper logic
  // ********************************************************
  logic       ctrl_wr;
  logic [7:0] tick_cnt_reg;
  logic [7:0] tick_cnt_next;

  assign ctrl_wr = sfr_wr && (sfr_addr == SAC_OFS_CTRL);

  // ticks of the current conversion only, tracking ticks excluded
  always_comb
  begin
    tick_cnt_next = tick_cnt_reg;
    if (!convert_active)
      tick_cnt_next = 8'h00;
    else if (sar_clock_tick)
      tick_cnt_next = tick_cnt_reg + 8'h01;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      tick_cnt_reg <= 8'h00;
    else
      tick_cnt_reg <= tick_cnt_next;
  end

  // ********************************************************
  // properties
  // ********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // completion with the converter still enabled, aborts excluded
  sequence s_conv_end;
    $fell(convert_active) && converter_active;
  endsequence

  property p_rd_upper;
    (($past(sfr_addr) == SAC_OFS_PAIR_CFG) || ($past(sfr_addr) == SAC_OFS_CHAN_SEL)) |-> (sfr_rdata[7:4] == 4'h0);
  endproperty
  property p_enable_write;
    ctrl_wr |=> (converter_active == $past(sfr_wdata[SAC_CTL_ENABLE]));
  endproperty
  property p_shutdown;
    !converter_active |-> (!convert_active && !track_active);
  endproperty
  property p_done_hold;
    (conversion_done_flag && !(ctrl_wr && !sfr_wdata[SAC_CTL_DONE])) |=> conversion_done_flag;
  endproperty
  property p_window_hold;
    (window_match_flag && !(ctrl_wr && !sfr_wdata[SAC_CTL_WINDOW])) |=> window_match_flag;
  endproperty
  property p_done_on_fall;
    s_conv_end |-> conversion_done_flag;
  endproperty
  property p_conv_len;
    s_conv_end |-> (tick_cnt_reg == 8'(CONV_SAR_CLKS));
  endproperty
  property p_diff_even;
    mux_differential |-> (!mux_input_pos[0] && !mux_temp_sensor);
  endproperty

  a_rd_upper:     assert property (p_rd_upper) else $error("mux register upper nibble not zero");
  a_enable_write: assert property (p_enable_write) else $error("enable output not following write");
  a_shutdown:     assert property (p_shutdown) else $error("activity while disabled");
  a_done_hold:    assert property (p_done_hold) else $error("done flag dropped without write");
  a_window_hold:  assert property (p_window_hold) else $error("window flag dropped without write");
  a_done_on_fall: assert property (p_done_on_fall) else $error("busy fell without done");
  a_conv_len:     assert property (p_conv_len) else $error("wrong sar tick count in conversion");
  a_diff_even:    assert property (p_diff_even) else $error("differential pair not on even input");
endmodule

bind sac_control sac_control_sva #(.CONV_SAR_CLKS(CONV_SAR_CLKS)) i_sac_control_sva (
  .core_clk(core_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .converter_active(converter_active),
  .track_active(track_active), .convert_active(convert_active), .sar_clock_tick(sar_clock_tick),
  .mux_input_pos(mux_input_pos), .mux_differential(mux_differential), .mux_temp_sensor(mux_temp_sensor),
  .conversion_done_flag(conversion_done_flag), .window_match_flag(window_match_flag)
);

`default_nettype wire

// file: sac_control_tb.sv
// Purpose: self-checking bench of the converter control unit
// Assumes: sar divisor kept at 2, so one tick every 3 cycles
// Notes:   conversion length shortened to keep the run brief
`default_nettype none

module sac_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sac_pkg::*;

  // ********************************************************
  // signals
  // ********************************************************
  localparam int unsigned CONV = 4;
  logic core_clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic tmr3 = 1'b0, tmr2 = 1'b0, ext_start = 1'b0;
  logic [15:0] gt_lim = 16'h0000, lt_lim = 16'h0300;
  logic [9:0] ana = 10'h2a5;
  logic conv_on, trk_on, cvt_on, tick, mdiff, mtemp, done, wflag;
  logic [2:0] mpos;
  sac_gain_t gain;
  int failures = 0, checked = 0;

  always #5 core_clk = ~core_clk;

  sac_control #(.CONV_SAR_CLKS(CONV)) i_sac_control (
    .core_clk(core_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer3_overflow(tmr3), .timer2_overflow(tmr2),
    .external_start_input(ext_start), .window_gt_limit(gt_lim), .window_lt_limit(lt_lim),
    .analog_result(ana), .converter_active(conv_on), .track_active(trk_on), .convert_active(cvt_on),
    .sar_clock_tick(tick), .mux_input_pos(mpos), .mux_differential(mdiff), .mux_temp_sensor(mtemp),
    .amplifier_gain(gain), .conversion_done_flag(done), .window_match_flag(wflag)
  );

  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    @(negedge core_clk);
    d = sfr_rdata;
  endtask

  task automatic word(output logic [15:0] w);
    rd(SAC_OFS_RES_HI, w[15:8]);
    rd(SAC_OFS_RES_LO, w[7:0]);
  endtask

  task automatic fire(input logic t3, input logic t2);
    @(negedge core_clk);
    tmr3 = t3;
    tmr2 = t2;
    @(negedge core_clk);
    tmr3 = 1'b0;
    tmr2 = 1'b0;
  endtask

  // waits for completion, counting tracking and converting ticks
  task automatic finish(output int trk, output int cvt);
    int n, last, gap;
    trk = 0;
    cvt = 0;
    last = 0;
    gap = 0;
    for (n = 0; n < 300 && done !== 1'b1; n++)
    begin
      if (tick === 1'b1)
      begin
        gap = n - last;
        last = n;
        if (cvt_on === 1'b1)
          cvt++;
        else
          trk++;
      end
      @(negedge core_clk);
    end
    chk("done flag", done, 1'b1);
    chk("tick spacing", gap[15:0], 16'd3);
  endtask

  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_regs();
    logic [7:0] ad [7] = '{8'hba, 8'hbb, 8'hbc, 8'hbe, 8'hbf, 8'he8, 8'hc0};
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'hf8, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [3:0] cd [8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hf};
    logic [4:0] mx [8] = '{5'h08, 5'h02, 5'h03, 5'h0c, 5'h06, 5'h07, 5'h10, 5'h10};
    logic [2:0] gn [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};
    logic [7:0] v;
    wr(8'hc0, 8'hff);
    for (int i = 0; i < 7; i++)
    begin
      rd(ad[i], v);
      chk("reset value", v, rv[i]);
    end
    wr(SAC_OFS_PAIR_CFG, 8'hf5);
    rd(SAC_OFS_PAIR_CFG, v);
    chk("pair config", v, 8'h05);
    for (int i = 0; i < 8; i++)
    begin
      wr(SAC_OFS_CHAN_SEL, {4'hf, cd[i]});
      chk("mux select", {mtemp, mdiff, mtemp ? 3'h0 : mpos}, mx[i]);
    end
    rd(SAC_OFS_CHAN_SEL, v);
    chk("channel select", v, 8'h0f);
    for (int g = 0; g < 8; g++)
    begin
      wr(SAC_OFS_CLK_GAIN, {5'd2, 3'(g)});
      chk("gain", gain, gn[g]);
    end
    wr(SAC_OFS_CHAN_SEL, 8'h00);
    wr(SAC_OFS_PAIR_CFG, 8'h00);
    $display("test registers done");
  endtask

  task automatic t_format();
    logic [15:0] w;
    int t, c;
    logic [7:0] ct [4] = '{8'h80, 8'h81, 8'h80, 8'h80};
    logic [15:0] ew [4] = '{16'h02a5, 16'ha940, 16'hfea5, 16'hfea5};
    logic [0:0] ef [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++)
    begin
      if (i == 2)
        wr(SAC_OFS_PAIR_CFG, 8'h01);
      // limits crossed over: flag outside the window, signed for the pair
      if (i == 3)
      begin
        gt_lim = 16'h0100;
        lt_lim = 16'h0000;
      end
      wr(SAC_OFS_CTRL, ct[i]);
      chk("flags cleared", {done, wflag}, 16'h0);
      chk("idle tracking", trk_on, 1'b1);
      wr(SAC_OFS_CTRL, ct[i] | 8'h10);
      finish(t, c);
      chk("tracking ticks", t[15:0], 16'd0);
      word(w);
      chk("result word", w, ew[i]);
      chk("window flag", wflag, ef[i]);
    end
    wr(SAC_OFS_PAIR_CFG, 8'h00);
    $display("test format done");
  endtask

  task automatic t_trigger();
    logic [7:0] v;
    int t, c;
    wr(SAC_OFS_CTRL, 8'h84);
    wr(SAC_OFS_CTRL, 8'h94);
    fire(1'b0, 1'b1);
    chk("refused start", {cvt_on, done}, 16'h0);
    fire(1'b1, 1'b0);
    rd(SAC_OFS_CTRL, v);
    chk("busy bit", v[4], 1'b1);
    finish(t, c);
    wr(SAC_OFS_CTRL, 8'h8c);
    fire(1'b0, 1'b1);
    finish(t, c);
    chk("timer2 start", c[15:0], 16'(CONV));
    wr(SAC_OFS_CTRL, 8'h88);
    ext_start = 1'b1;
    finish(t, c);
    ext_start = 1'b0;
    rd(SAC_OFS_CTRL, v);
    chk("done not busy", v & 8'h30, 8'h20);
    wr(SAC_OFS_CTRL, 8'h80);
    wr(SAC_OFS_CTRL, 8'h90);
    wr(SAC_OFS_CTRL, 8'h00);
    chk("abort", {conv_on, cvt_on, trk_on, done}, 16'h0);
    $display("test triggers done");
  endtask

  task automatic t_low_power();
    int t, c;
    wr(SAC_OFS_CTRL, 8'hc0);
    chk("no idle tracking", trk_on, 1'b0);
    wr(SAC_OFS_CTRL, 8'hd0);
    finish(t, c);
    chk("track ticks", t[15:0], 16'd3);
    wr(SAC_OFS_CTRL, 8'hc4);
    fire(1'b1, 1'b0);
    finish(t, c);
    chk("timer3 track ticks", t[15:0], 16'd3);
    wr(SAC_OFS_CTRL, 8'hc8);
    repeat (3) @(negedge core_clk);
    chk("track while low", {trk_on, cvt_on}, 16'h2);
    ext_start = 1'b1;
    finish(t, c);
    chk("convert on rise", t[15:0], 16'd0);
    chk("no track while high", trk_on, 1'b0);
    ext_start = 1'b0;
    $display("test low power done");
  endtask

  initial
  begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    t_regs();
    t_format();
    t_trigger();
    t_low_power();
    print_verdict();
  end

  // the whole run needs a few hundred cycles
  initial
  begin
    #200us;
    failures++;
    print_verdict();
  end
endmodule

`default_nettype wire
